// >>> logic/sfh_fifo.sv
// Purpose: Small word buffer with valid and ready on both sides.
// Assumes: Flush empties the buffer in one cycle.
// Notes:   The filling side's ready comes straight from a flip-flop.
module sfh_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 2
) (
  input wire logic  mclk,
  input wire logic  rst_n,
  input wire logic  flush,
  sfh_stream_if.snk in_s,
  sfh_stream_if.src out_s
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          in_rdy;
  logic          push;
  logic          pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : ptr_inc

  assign push        = in_s.valid & in_rdy;
  assign pop         = out_s.valid & out_s.ready;
  assign in_s.ready  = in_rdy;
  assign out_s.valid = (count != '0);
  assign out_s.data  = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (flush) begin
      next_count = '0;
    end else if (push && !pop) begin
      next_count = count + CW'(1);
    end else if (pop && !push) begin
      next_count = count - CW'(1);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count  <= '0;
      in_rdy <= 1'b1;
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      count  <= next_count;
      // A full buffer stalls the source until the link drains a word.
      in_rdy <= (next_count != CW'(DEPTH));
      wr_ptr <= flush ? '0 : (push ? ptr_inc(wr_ptr) : wr_ptr);
      rd_ptr <= flush ? '0 : (pop ? ptr_inc(rd_ptr) : rd_ptr);
    end
  end

  always_ff @(posedge mclk) begin
    if (push && !flush) begin
      mem[wr_ptr] <= in_s.data;
    end
  end

endmodule : sfh_fifo

// >>> logic/sfh_host_if.sv
// Purpose: Serial bus front end of a page organised flash memory.
// Assumes: Link clock stops outside frames; mclk runs free.
// Notes:   Read data must be queued before the byte boundary that starts output.
module sfh_host_if #(
  parameter int unsigned PROG_TIME_NS = 200000,
  parameter logic [511:0] UNIQUE_ID   = {64{8'hA5}}  // Arbitrary value.
) (
  input  wire logic                mclk,
  input  wire logic                rst_b,
  input  wire logic                sck,
  input  wire logic                cs_b,
  input  wire logic [3:0]          io_in,
  output var  logic [3:0]          io_out,
  output var  logic [3:0]          io_oe,
  output var  logic                rx_valid,
  output var  logic                rx_first,
  output var  logic [7:0]          rx_data,
  output var  logic                frame_end,
  input  wire logic                tx_valid,
  input  wire logic [7:0]          tx_data,
  output wire logic                tx_ready,
  input  wire sfh_pkg::sfh_width_e out_width,
  input  wire logic                quad_io_enable_bit,
  input  wire logic                page_size_512,
  input  wire logic                buf_sel,
  input  wire logic                buf_start,
  input  wire logic [9:0]          buf_start_addr,
  input  wire logic                buf_capture,
  input  wire logic                buf_rd_sel,
  input  wire logic [9:0]          buf_rd_addr,
  output var  logic [7:0]          buf_rd_data,
  input  wire logic                otp_wr,
  input  wire logic [6:0]          otp_addr,
  input  wire logic [7:0]          otp_wdata,
  output var  logic [7:0]          otp_rd_data,
  output var  logic                otp_err,
  input  wire logic                op_start,
  input  wire logic                op_buf,
  output var  logic                busy,
  output var  logic                standby
);
  import sfh_pkg::*;

  localparam int unsigned PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BW          = $clog2(PROG_CYCLES + 1);

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic rst_q1;
  logic rst_n;
  logic cs_s1;
  logic cs_s2;
  logic cs_d;
  logic rxt_s1;
  logic rxt_s2;
  logic rxt_d;
  logic ack_s1;
  logic ack_s2;
  logic io3_s1;
  logic io3_s2;
  logic pin_rst;
  logic frame_on;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // Frame flops of the link side are cleared whenever the device is deselected.
  logic sck_rst_n;
  assign sck_rst_n = rst_n & ~cs_b;

  logic rx_tgl;
  logic ack_tgl;
  logic req_tgl;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s1  <= 1'b1;
      cs_s2  <= 1'b1;
      cs_d   <= 1'b1;
      rxt_s1 <= 1'b0;
      rxt_s2 <= 1'b0;
      rxt_d  <= 1'b0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      io3_s1 <= 1'b1;
      io3_s2 <= 1'b1;
    end else begin
      cs_s1  <= cs_b;
      cs_s2  <= cs_s1;
      cs_d   <= cs_s2;
      rxt_s1 <= rx_tgl;
      rxt_s2 <= rxt_s1;
      rxt_d  <= rxt_s2;
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
      io3_s1 <= io_in[3];
      io3_s2 <= io3_s1;
    end
  end

  // With quad enable clear the top line is the reset pin, never data.
  assign pin_rst  = ~quad_io_enable_bit & ~io3_s2;
  assign frame_on = ~cs_s2;

  // ----------------------------------------------------------------
  // Link side: capture on rising edge
  // ----------------------------------------------------------------
  sfh_phase_e phase;
  logic [6:0] rx_sh;
  logic [2:0] rx_cnt;
  logic       byte_seen;
  logic [7:0] rx_byte;
  logic       rx_cmd;

  always_ff @(posedge sck or negedge sck_rst_n) begin
    if (!sck_rst_n) begin
      rx_sh     <= '0;
      rx_cnt    <= '0;
      byte_seen <= 1'b0;
    end else if (phase == SFH_PH_IN) begin
      rx_sh  <= {rx_sh[5:0], io_in[0]};
      rx_cnt <= rx_cnt + 3'h1;
      if (rx_cnt == RX_LAST_BIT) begin
        byte_seen <= 1'b1;
      end
    end
  end

  // The toggle outlives the frame so that deselection is never taken for a byte.
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      rx_byte <= '0;
      rx_cmd  <= 1'b0;
      rx_tgl  <= 1'b0;
    end else if (!cs_b && phase == SFH_PH_IN && rx_cnt == RX_LAST_BIT) begin
      rx_byte <= {rx_sh, io_in[0]};
      rx_cmd  <= ~byte_seen;
      rx_tgl  <= ~rx_tgl;
    end
  end

  // ----------------------------------------------------------------
  // Link side: drive on falling edge
  // ----------------------------------------------------------------
  logic [7:0] tx_hold;
  logic       req_s1;
  logic       req_s2;
  logic [1:0] wid_s1;
  logic [1:0] wid_s2;
  logic [1:0] eff_width;
  sfh_width_e lane_w;
  logic [7:0] tx_sh;
  logic [2:0] tx_cnt;
  logic       avail;
  logic [7:0] next_byte;

  assign lane_w    = sfh_width_e'(wid_s2);
  assign avail     = (req_s2 != ack_tgl);
  assign next_byte = avail ? tx_hold : UNDERRUN_BYTE;

  always_ff @(negedge sck or negedge sck_rst_n) begin
    if (!sck_rst_n) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      wid_s1 <= '0;
      wid_s2 <= '0;
    end else begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      wid_s1 <= eff_width;
      wid_s2 <= wid_s1;
    end
  end

  // In mode 3 the first falling edge comes before any bit, so output waits for a whole byte.
  always_ff @(negedge sck or negedge sck_rst_n) begin
    if (!sck_rst_n) begin
      phase   <= SFH_PH_IN;
      io_oe   <= '0;
      io_out  <= '0;
      tx_sh   <= '0;
      tx_cnt  <= '0;
      ack_tgl <= 1'b0;
    end else begin
      case (phase)
        SFH_PH_IN: begin
          if (byte_seen && rx_cnt == '0 && avail) begin
            phase   <= SFH_PH_OUT;
            io_oe   <= sfh_oe_mask(lane_w);
            io_out  <= sfh_lanes(tx_hold, lane_w);
            tx_sh   <= sfh_advance(tx_hold, lane_w);
            tx_cnt  <= sfh_last_edge(lane_w);
            ack_tgl <= ~ack_tgl;
          end
        end
        SFH_PH_OUT: begin
          if (tx_cnt != '0) begin
            io_out <= sfh_lanes(tx_sh, lane_w);
            tx_sh  <= sfh_advance(tx_sh, lane_w);
            tx_cnt <= tx_cnt - 3'h1;
          end else begin
            // A late byte is replaced by all ones rather than stretching the clock.
            io_out  <= sfh_lanes(next_byte, lane_w);
            tx_sh   <= sfh_advance(next_byte, lane_w);
            tx_cnt  <= sfh_last_edge(lane_w);
            ack_tgl <= avail ? ~ack_tgl : ack_tgl;
          end
        end
        default: begin
          phase <= SFH_PH_IN;
          io_oe <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Core side: received bytes and frame end
  // ----------------------------------------------------------------
  logic rx_evt;

  assign rx_evt = (rxt_s2 != rxt_d) & ~pin_rst;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_valid  <= 1'b0;
      rx_first  <= 1'b0;
      rx_data   <= '0;
      frame_end <= 1'b0;
    end else begin
      rx_valid  <= rx_evt;
      rx_first  <= rx_evt & rx_cmd;
      rx_data   <= rx_evt ? rx_byte : rx_data;
      frame_end <= cs_s2 & ~cs_d;
    end
  end

  // ----------------------------------------------------------------
  // Core side: read data towards the link
  // ----------------------------------------------------------------
  sfh_stream_if #(.W(8)) tx_in_s ();
  sfh_stream_if #(.W(8)) tx_out_s ();

  assign tx_in_s.valid  = tx_valid;
  assign tx_in_s.data   = tx_data;
  assign tx_ready       = tx_in_s.ready;
  assign tx_out_s.ready = frame_on & ~pin_rst & (req_tgl == ack_s2);

  sfh_fifo #(
    .W     (8),
    .DEPTH (TX_DEPTH)
  ) u_tx_fifo (
    .mclk  (mclk),
    .rst_n (rst_n),
    .flush (pin_rst),
    .in_s  (tx_in_s),
    .out_s (tx_out_s)
  );

  // The hold byte changes only while no request is outstanding, so the link reads it steady.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      req_tgl <= 1'b0;
      tx_hold <= '0;
    end else if (!frame_on) begin
      req_tgl <= 1'b0;
    end else if (tx_out_s.valid && tx_out_s.ready) begin
      tx_hold <= tx_out_s.data;
      req_tgl <= ~req_tgl;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      eff_width <= SFH_W1;
    end else if (out_width == SFH_W4 && !quad_io_enable_bit) begin
      eff_width <= SFH_W1;
    end else begin
      eff_width <= out_width;
    end
  end

  // ----------------------------------------------------------------
  // Self-timed program cycle
  // ----------------------------------------------------------------
  logic [BW-1:0] busy_cnt;
  logic          busy_buf;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy     <= 1'b0;
      busy_cnt <= '0;
      busy_buf <= 1'b0;
      standby  <= 1'b1;
    end else begin
      if (pin_rst) begin
        busy     <= 1'b0;
        busy_cnt <= '0;
      end else if (busy) begin
        busy_cnt <= busy_cnt - BW'(1);
        busy     <= (busy_cnt != '0);
      end else if (op_start) begin
        busy     <= 1'b1;
        busy_cnt <= BW'(PROG_CYCLES - 1);
        busy_buf <= op_buf;
      end
      // Deselection alone never leads to a deeper power state.
      standby <= cs_s2 & ~busy;
    end
  end

  // ----------------------------------------------------------------
  // Page buffers
  // ----------------------------------------------------------------
  logic [7:0] buf_mem [BUF_COUNT][PAGE_BYTES_STD];
  logic [9:0] buf_idx;
  logic [9:0] page_last;
  logic       buf_wr;

  assign page_last = page_size_512 ? PAGE_LAST_ALT : PAGE_LAST_STD;
  // The buffer being programmed is locked; the other keeps taking data.
  assign buf_wr = rx_evt & buf_capture & ~(busy & (busy_buf == buf_sel));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      buf_idx <= '0;
    end else if (buf_start) begin
      buf_idx <= (buf_start_addr > page_last) ? '0 : buf_start_addr;
    end else if (buf_wr) begin
      buf_idx <= (buf_idx == page_last) ? '0 : buf_idx + 10'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (buf_wr && !buf_start) begin
      buf_mem[buf_sel][buf_idx] <= rx_byte;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      buf_rd_data <= '0;
    end else if (buf_rd_addr <= page_last) begin
      buf_rd_data <= buf_mem[buf_rd_sel][buf_rd_addr];
    end else begin
      buf_rd_data <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Security area
  // ----------------------------------------------------------------
  localparam int unsigned USER_BYTES = OTP_BYTES - OTP_FACTORY_BYTES;

  logic [7:0]            otp_user [USER_BYTES];
  logic [USER_BYTES-1:0] otp_done;
  logic                  otp_factory;
  logic [5:0]            otp_uidx;

  assign otp_factory = (otp_addr < OTP_AW'(OTP_FACTORY_BYTES));
  assign otp_uidx    = otp_addr[5:0];

  // Each user byte may be programmed once; a second write is refused.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      otp_done <= '0;
      otp_err  <= 1'b0;
    end else begin
      otp_err <= otp_wr & (otp_factory | otp_done[otp_uidx]);
      if (otp_wr && !otp_factory && !otp_done[otp_uidx]) begin
        otp_done[otp_uidx] <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (otp_wr && !otp_factory && !otp_done[otp_uidx]) begin
      otp_user[otp_uidx] <= otp_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      otp_rd_data <= '0;
    end else if (otp_factory) begin
      otp_rd_data <= UNIQUE_ID[{otp_uidx, 3'h0} +: 8];
    end else begin
      otp_rd_data <= otp_done[otp_uidx] ? otp_user[otp_uidx] : UNDERRUN_BYTE;
    end
  end

endmodule : sfh_host_if

// >>> logic/sfh_pkg.sv
// Purpose: Shared constants, types and helpers for the serial flash host interface.
// Assumes: Link data is byte oriented and sent most significant bit first.
// Notes:   Contract
package sfh_pkg;

  // ----------------------------------------------------------------
  // Timing and sizes
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS     = 40;
  localparam int unsigned PAGE_BYTES_STD    = 528;
  localparam int unsigned PAGE_BYTES_ALT    = 512;
  localparam int unsigned BUF_AW            = 10;
  localparam int unsigned BUF_COUNT         = 2;
  localparam logic [9:0]  PAGE_LAST_STD     = 10'h20F;
  localparam logic [9:0]  PAGE_LAST_ALT     = 10'h1FF;
  localparam int unsigned OTP_BYTES         = 128;
  localparam int unsigned OTP_FACTORY_BYTES = 64;
  localparam int unsigned OTP_AW            = 7;
  localparam int unsigned TX_DEPTH          = 2;
  localparam logic [7:0]  UNDERRUN_BYTE     = 8'hFF;
  localparam logic [2:0]  RX_LAST_BIT       = 3'h7;
  localparam logic [3:0]  OE_MASK_W1        = 4'h2;
  localparam logic [3:0]  OE_MASK_W2        = 4'h3;
  localparam logic [3:0]  OE_MASK_W4        = 4'hF;

  typedef enum logic [1:0] {SFH_W1, SFH_W2, SFH_W4} sfh_width_e;
  typedef enum logic {SFH_PH_IN, SFH_PH_OUT} sfh_phase_e;

  // ----------------------------------------------------------------
  // Lane helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] sfh_last_edge(input sfh_width_e w);
    case (w)
      SFH_W2:  sfh_last_edge = 3'h3;
      SFH_W4:  sfh_last_edge = 3'h1;
      default: sfh_last_edge = 3'h7;
    endcase
  endfunction : sfh_last_edge

  function automatic logic [3:0] sfh_lanes(input logic [7:0] b, input sfh_width_e w);
    case (w)
      SFH_W2:  sfh_lanes = {2'h0, b[7], b[6]};
      SFH_W4:  sfh_lanes = b[7:4];
      default: sfh_lanes = {2'h0, b[7], 1'h0};
    endcase
  endfunction : sfh_lanes

  function automatic logic [7:0] sfh_advance(input logic [7:0] b, input sfh_width_e w);
    case (w)
      SFH_W2:  sfh_advance = {b[5:0], 2'h0};
      SFH_W4:  sfh_advance = {b[3:0], 4'h0};
      default: sfh_advance = {b[6:0], 1'h0};
    endcase
  endfunction : sfh_advance

  function automatic logic [3:0] sfh_oe_mask(input sfh_width_e w);
    case (w)
      SFH_W2:  sfh_oe_mask = OE_MASK_W2;
      SFH_W4:  sfh_oe_mask = OE_MASK_W4;
      default: sfh_oe_mask = OE_MASK_W1;
    endcase
  endfunction : sfh_oe_mask

endpackage : sfh_pkg

// >>> logic/sfh_stream_if.sv
// Purpose: Valid and ready word stream between the block's own modules.
// Assumes: Both ends share one clock.
// Notes:   A word moves on a cycle where valid and ready are both high.
interface sfh_stream_if #(
  parameter int unsigned W = 8
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sfh_stream_if

// >>> tb/sfh_host_if_properties.sv
// Purpose: Port level checks of the serial flash front end.
// Assumes: 40 ns core clock; PROG_TIME_NS equals the bound instance value.
// Notes:   The bind at the foot attaches it to every instance.
module sfh_host_if_properties #(
  parameter int unsigned PROG_TIME_NS = 200000
) (
  input wire logic                mclk,
  input wire logic                rst_b,
  input wire logic                cs_b,
  input wire logic [3:0]          io_in,
  input wire logic [3:0]          io_oe,
  input wire logic                rx_valid,
  input wire logic                rx_first,
  input wire logic                frame_end,
  input wire logic                tx_valid,
  input wire logic                tx_ready,
  input wire sfh_pkg::sfh_width_e out_width,
  input wire logic                quad_io_enable_bit,
  input wire logic                op_start,
  input wire logic                busy,
  input wire logic                standby
);
  timeunit 1ns;
  timeprecision 100ps;
  import sfh_pkg::*;
  localparam int BUSY_LEN = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  int unsigned busy_cnt;
  logic        in_cmd;
  logic [3:0]  exp_oe;

  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy ? busy_cnt + 1 : 0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      in_cmd <= 1'b0;
    end else if (frame_end) begin
      in_cmd <= 1'b0;
    end else if (rx_valid) begin
      in_cmd <= 1'b1;
    end
  end

  always_comb begin
    case (out_width)
      SFH_W2:  exp_oe = 4'h3;
      SFH_W4:  exp_oe = quad_io_enable_bit ? 4'hF : 4'h2;
      default: exp_oe = 4'h2;
    endcase
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  sequence s_cs_rise;
    $rose(cs_b);
  endsequence
  sequence s_end_seen;
    ##[1:4] frame_end;
  endsequence

  AST_OE_IDLE: assert property ($past(cs_b) && cs_b |-> io_oe == 4'h0)
    else $error("io_oe driven while deselected");
  AST_RX_IDLE: assert property (cs_b [*8] |-> !rx_valid)
    else $error("byte received while deselected");
  AST_FRAME_END: assert property (s_cs_rise |-> s_end_seen)
    else $error("select rise not reported");
  AST_FIRST: assert property (rx_valid |-> rx_first == !in_cmd)
    else $error("first byte flag wrong");
  AST_STANDBY: assert property ((cs_b && !busy) [*5] |-> standby)
    else $error("no standby when idle");
  AST_BUSY_STBY: assert property (busy ##1 busy |-> !standby)
    else $error("standby during timed cycle");
  AST_OP_BUSY: assert property (op_start && !busy && io_in[3] && $past(io_in[3], 2) |=> busy)
    else $error("timed cycle not started");
  AST_BUSY_LEN: assert property ($fell(busy) && io_in[3] && $past(io_in[3], 4) |-> busy_cnt == BUSY_LEN)
    else $error("timed cycle length wrong");
  AST_OE_WIDTH: assert property (io_oe != 4'h0 |-> io_oe == exp_oe)
    else $error("output lanes do not match width");
  AST_TX_FULL: assert property ((tx_valid && tx_ready && cs_b) [*2] |=> !tx_ready)
    else $error("buffer ready when full");
endmodule : sfh_host_if_properties

bind sfh_host_if sfh_host_if_properties #(.PROG_TIME_NS(PROG_TIME_NS)) u_props (.*);

// >>> tb/sfh_spi_host.sv
// Purpose: Behavioural host that clocks frames into the front end.
// Assumes: Link clock of 125 ns that stands still between frames.
// Notes:   Line 1 undriven reads the inverse of the device's last bit; line 2 reads high.
module sfh_spi_host (
  output var  logic       sck,
  output var  logic       cs_b,
  output wire logic [3:0] io_in,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       mode3 = 1'b0;
  logic       si = 1'b0;
  logic       pin3 = 1'b1;
  logic [3:0] oe_seen = 4'h0;

  // ----------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------
  assign io_in[0] = io_oe[0] ? io_out[0] : si;
  assign io_in[1] = io_oe[1] ? io_out[1] : !io_out[1];
  assign io_in[2] = io_oe[2] ? io_out[2] : 1'b1;
  assign io_in[3] = io_oe[3] ? io_out[3] : pin3;
  initial begin
    sck = 1'b0;
    cs_b = 1'b1;
  end

  task automatic sel();
    sck = mode3;
    #7;
    cs_b = 1'b0;
    #40;
  endtask : sel

  task automatic desel();
    #62;
    sck = mode3;
    #20;
    cs_b = 1'b1;
    #200;
  endtask : desel

  // Lanes are read just before the rising edge, as a real host does.
  task automatic xfer(input logic [7:0] tx, input int w, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < 8 / w; i++) begin
      sck = 1'b0;
      si = tx[7 - i];
      #62;
      rx = (rx << w) | (w == 4 ? {4'h0, io_in} : (w == 2 ? {6'h0, io_in[1:0]} : {7'h0, io_in[1]}));
      oe_seen = io_oe;
      sck = 1'b1;
      #63;
    end
  endtask : xfer
endmodule : sfh_spi_host

// >>> tb/testbench.sv
// Purpose: Self-checking bench of the serial flash front end.
// Assumes: Program time shortened to 4000 ns, that is 100 core cycles.
// Notes:   Read frames use table rows; the rest is written out by hand.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import sfh_pkg::*;
  typedef struct packed {
    logic        m3;
    sfh_width_e  w;
    logic        qe;
    logic [7:0]  cmd;
    logic [15:0] dat;
    logic [3:0]  oe;
  } sfh_row_s;
  logic       mclk, rst_b, sck, cs_b, rx_valid, rx_first, frame_end, tx_valid, tx_ready;
  logic       quad_io_enable_bit, page_size_512, buf_sel, buf_start, buf_capture, buf_rd_sel;
  logic       otp_wr, otp_err, op_start, op_buf, busy, standby;
  logic [3:0] io_in, io_out, io_oe;
  logic [7:0] rx_data, tx_data, buf_rd_data, otp_wdata, otp_rd_data, v;
  logic [9:0] buf_start_addr, buf_rd_addr;
  logic [6:0] otp_addr;
  sfh_width_e out_width;
  int         n_errors, n_tests, n_fe, n_busy, k, ln;
  logic [8:0] rxq [$];
  sfh_row_s   r;
  sfh_row_s   rows [5] = '{
    '{1'b0, SFH_W1, 1'b0, 8'h0B, 16'hA55A, 4'h2},
    '{1'b1, SFH_W1, 1'b0, 8'hE8, 16'h3C81, 4'h2},
    '{1'b0, SFH_W2, 1'b0, 8'h3B, 16'h96E1, 4'h3},
    '{1'b1, SFH_W4, 1'b1, 8'h6B, 16'h5AC3, 4'hF},
    '{1'b0, SFH_W4, 1'b0, 8'h6B, 16'h7E18, 4'h2}};

  sfh_host_if #(.PROG_TIME_NS(4000)) dut (.*);
  sfh_spi_host host (.*);

  always #20 mclk = ~mclk;
  always @(negedge mclk) begin
    if (rx_valid === 1'b1) begin
      rxq.push_back({rx_first, rx_data});
    end
    n_fe += (frame_end === 1'b1);
    n_busy += (busy === 1'b1);
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] s);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask : chk

  // The buffer is empty on entry, so both words go back to back.
  task automatic push2(input logic [15:0] d);
    @(negedge mclk);
    tx_valid = 1'b1;
    tx_data = d[15:8];
    @(negedge mclk);
    tx_data = d[7:0];
    @(negedge mclk);
    tx_valid = 1'b0;
    @(negedge mclk);
  endtask : push2

  task automatic otp_w(input logic [6:0] a, input logic [7:0] d, input logic e);
    logic s;
    @(negedge mclk);
    otp_addr = a;
    otp_wdata = d;
    otp_wr = 1'b1;
    @(negedge mclk);
    otp_wr = 1'b0;
    s = otp_err;
    @(negedge mclk);
    chk("otp_err", {9'h0, e}, {9'h0, s | otp_err});
  endtask : otp_w

  task automatic pulse_op();
    @(negedge mclk);
    op_start = 1'b1;
    @(negedge mclk);
    op_start = 1'b0;
  endtask : pulse_op

  task automatic tally_and_finish();
    if (n_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #200000;
    n_errors++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    out_width = SFH_W1;
    {tx_valid, op_start, op_buf, otp_wr, buf_start, buf_capture, buf_sel, buf_rd_sel} = '0;
    {quad_io_enable_bit, page_size_512, tx_data, otp_wdata, buf_start_addr, buf_rd_addr, otp_addr} = '0;
    repeat (12) @(negedge mclk);
    rst_b = 1'b1;
    repeat (4) @(negedge mclk);
    chk("idle", 10'h050, {standby, busy, tx_ready, io_oe});
    foreach (rows[i]) begin
      r = rows[i];
      @(negedge mclk);
      host.mode3 = r.m3;
      out_width = r.w;
      quad_io_enable_bit = r.qe;
      rxq.delete();
      k = n_fe;
      push2(r.dat);
      chk("tx_full", 10'h0, {9'h0, tx_ready});
      host.sel();
      host.xfer(r.cmd, 1, v);
      chk("oe_cmd", 10'h0, {6'h0, host.oe_seen});
      ln = r.oe == 4'hF ? 4 : (r.oe == 4'h3 ? 2 : 1);
      host.xfer(8'h00, ln, v);
      chk("oe_rd", {6'h0, r.oe}, {6'h0, host.oe_seen});
      chk("rd0", {2'h0, r.dat[15:8]}, {2'h0, v});
      host.xfer(8'h00, ln, v);
      // A quad byte every two edges outruns the hand-over, so the second byte underruns.
      chk("rd1", {2'h0, (r.oe == 4'hF) ? UNDERRUN_BYTE : r.dat[7:0]}, {2'h0, v});
      host.desel();
      chk("oe_off", 10'h0, {6'h0, io_oe});
      chk("fe", 10'(k + 1), 10'(n_fe));
      chk("rx_cmd", {2'h1, r.cmd}, {1'b0, rxq[0]});
      chk("tx_empty", 10'h1, {9'h0, tx_ready});
    end
    rxq.delete();
    host.xfer(8'h81, 1, v);
    host.desel();
    chk("rx_idle", 10'h0, 10'(rxq.size()));
    @(negedge mclk);
    buf_start_addr = 10'h20F;
    buf_start = 1'b1;
    buf_capture = 1'b1;
    @(negedge mclk);
    buf_start = 1'b0;
    host.sel();
    host.xfer(8'hC5, 1, v);
    host.xfer(8'h3A, 1, v);
    host.desel();
    chk("rx_next", {2'h0, 8'h3A}, {1'b0, rxq[1]});
    @(negedge mclk);
    buf_capture = 1'b0;
    buf_rd_addr = 10'h20F;
    @(negedge mclk);
    chk("buf_last", 10'h0C5, {2'h0, buf_rd_data});
    buf_rd_addr = 10'h000;
    @(negedge mclk);
    chk("buf_wrap", 10'h03A, {2'h0, buf_rd_data});
    page_size_512 = 1'b1;
    buf_rd_addr = 10'h20F;
    @(negedge mclk);
    chk("buf_512", 10'h0, {2'h0, buf_rd_data});
    otp_w(7'h3F, 8'h11, 1'b1);
    otp_w(7'h40, 8'h5A, 1'b0);
    otp_w(7'h40, 8'h00, 1'b1);
    repeat (2) @(negedge mclk);
    chk("otp_rd", 10'h05A, {2'h0, otp_rd_data});
    n_busy = 0;
    pulse_op();
    chk("busy", 10'h1, {9'h0, busy});
    host.sel();
    host.desel();
    chk("stby_busy", 10'h0, {9'h0, standby});
    pulse_op();
    for (k = 0; k < 200 && busy !== 1'b0; k++) begin
      @(negedge mclk);
    end
    repeat (6) @(negedge mclk);
    chk("busy_len", 10'(4000 / CLK_PERIOD_NS), 10'(n_busy));
    chk("stby", 10'h1, {9'h0, standby});
    push2(16'h1234);
    pulse_op();
    repeat (5) @(negedge mclk);
    host.pin3 = 1'b0;
    repeat (4) @(negedge mclk);
    chk("pin_abort", 10'h1, {8'h0, busy, tx_ready});
    pulse_op();
    repeat (3) @(negedge mclk);
    chk("pin_hold", 10'h0, {9'h0, busy});
    host.pin3 = 1'b1;
    tally_and_finish();
  end
endmodule : testbench
